// file: pkg/skjcu_defs.vh
// Constants for the skip and conditional jump unit.
// Assumes inclusion by the unit's design file, its monitor and its bench.
`ifndef SKJCU_DEFS_VH
`define SKJCU_DEFS_VH

// Instruction word field positions.
`define SKJCU_IND_BIT 23
`define SKJCU_OP_HI 22
`define SKJCU_OP_LO 18
`define SKJCU_COND_HI 17
`define SKJCU_COND_LO 16
`define SKJCU_IDX_HI 15
`define SKJCU_IDX_LO 14
`define SKJCU_ADR_HI 13
`define SKJCU_ADR_LO 0
`define SKJCU_SIGN_BIT 23

// Operation codes (octal in the listing).
`define SKJCU_OP_STEST 5'h04
`define SKJCU_OP_SROT 5'h05
`define SKJCU_OP_MCMP 5'h0d
`define SKJCU_OP_CSUB 5'h0f
`define SKJCU_OP_SENSE 5'h07
`define SKJCU_OP_JACC 5'h1d
`define SKJCU_OP_JSW 5'h1e

// Condition designator values.
`define SKJCU_C_PLUS 2'h0
`define SKJCU_C_MINUS 2'h1
`define SKJCU_C_ZERO 2'h2
`define SKJCU_C_NZERO 2'h3

// Sense group selectors held in the condition designator.
`define SKJCU_G_SWITCH 2'h0
`define SKJCU_G_INRDY 2'h1
`define SKJCU_G_OUTLN 2'h2
`define SKJCU_G_IND 2'h3

// Jump selectors.
`define SKJCU_J_QPLUS 2'h3
`define SKJCU_J_SW1 2'h1
`define SKJCU_J_SW2 2'h2

// Indicator group select bits in the address field.
`define SKJCU_I_OVF 0
`define SKJCU_I_DIV 3
`define SKJCU_I_PAR 6
`define SKJCU_I_ACCNEG 9
`define SKJCU_I_EXTNEG 10
`define SKJCU_I_ACCZ 11
`define SKJCU_I_RNG 12
`define SKJCU_I_LOCK 13
`define SKJCU_I_LAMP 2

// Register map, byte addresses.
`define SKJCU_A_CTRL 8'h00
`define SKJCU_A_STAT 8'h04
`define SKJCU_A_PC 8'h08
`define SKJCU_CTRL_RST 1'h1

`endif

// file: rtl/skjcu_unit.v
// Skip and conditional jump unit of the 24-bit sequencer.
// Assumes the sequencer supplies the fetched word, indexed and
// effective addresses and current PC, and waits for the done pulse.
// Memory requests stay up until acknowledged, however many wait states pass.
//
// Notes on behaviour
// - Bit 23 indirect, 22-18 opcode, 17-16 condition, 15-14 index, 13-0 address.
// - Storage test reads indexed word, tests condition, skips; no indirect, two cycles.
// - Compare-subtract operand is accumulator minus memory word, both kept.
// - Condition 0 plus, 1 minus, 2 zero, 3 non-zero.
// - Storage rotate rotates word left one, writes back, tests rotated value.
// - Masked compare: accumulator minus (extension AND word), indirect allowed, two cycles.
// - Switch skip ORs switches AND mask; one cycle, no state change.
// - Input-ready skip when any masked channel has input data; one cycle.
// - Output-lines skip when any masked channel has free output lines.
// - Indicator group ignores indexing and indirection, one cycle each.
// - Overflow skip skips when set and clears overflow unless a new overflow arrives in that cycle.
// - Divide error skip skips when set and clears it unless a new divide error arrives in that cycle.
// - Parity skip skips on odd shift parity and resets it even.
// - Accumulator negative skip tests bit 23, accumulator unchanged.
// - Extension negative and accumulator zero skips alter nothing.
// - Range overflow skip skips when set and clears the indicator.
// - Lockout-clear skip skips when lockout off, lockout unchanged.
// - Operator flag sets lamp; only the operator press clears it.
// - Accumulator jumps on plus, minus or zero load effective address, one cycle.
// - Opcode 35 designator 3 jumps when extension sign plus, one cycle.
// - Opcode 36 designator 1 or 2 jumps when that switch is on.

`include "skjcu_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module skjcu_unit (
   // Clock and reset.
   input wire mclk,
   input wire rst_n,
   // Instruction from the sequencer.
   input wire instValid,
   input wire [23:0] instWord,
   input wire [13:0] idxAddr,
   input wire [13:0] effAddr,
   input wire [13:0] curPc,
   // Processor registers.
   input wire [23:0] accA,
   input wire [23:0] extQ,
   // Panel, channels and lockout.
   input wire [15:0] senseSw,
   input wire [15:0] chanInAvail,
   input wire [15:0] chanOutAvail,
   input wire masterLockout,
   input wire lampPress,
   // Indicator events from the arithmetic unit.
   input wire ovfSet,
   input wire divErrSet,
   input wire shiftOne,
   input wire rangeOvfSet,
   // Core memory port.
   input wire memAck,
   input wire [23:0] memRdata,
   output reg memRd_q,
   output reg memWr_q,
   output reg [13:0] memAddr_q,
   output reg [23:0] memWdata_q,
   // Result to the sequencer.
   output reg ready_q,
   output reg done_q,
   output reg [13:0] pcNext_q,
   output reg skipTaken_q,
   output reg jumpTaken_q,
   // Indicators and lamp.
   output reg ovf_q,
   output reg divErr_q,
   output reg parOdd_q,
   output reg rangeOvf_q,
   output reg lamp_q,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output reg pready_q,
   output reg pslverr_q
);

   // One-hot states: idle, waiting for the read, waiting for the write-back.
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_READ = 3'b010;
   localparam [2:0] S_WRITE = 3'b100;

   reg [2:0] state_q;
   reg enable_q;
   // Opcode, designator and PC are held for the memory kinds.
   reg [4:0] op_q;
   reg [1:0] cond_q;
   reg [13:0] pc_q;

   // Decoded fields of the incoming word.
   // The indirect flag is not read here: the sequencer resolves it into effAddr.
   wire [4:0] opIn = instWord[`SKJCU_OP_HI:`SKJCU_OP_LO];
   wire [1:0] condIn = instWord[`SKJCU_COND_HI:`SKJCU_COND_LO];
   wire [13:0] adrIn = instWord[`SKJCU_ADR_HI:`SKJCU_ADR_LO];
   wire [15:0] maskIn = instWord[`SKJCU_IDX_HI:`SKJCU_ADR_LO];
   wire start = instValid & ready_q;

   // Condition designator test on a 24-bit operand.
   // A zero operand carries a plus sign, so designator 0 skips on zero too.
   function condMet;
      input [1:0] c;
      input [23:0] v;
      begin
         case (c)
            `SKJCU_C_PLUS: condMet = ~v[`SKJCU_SIGN_BIT];
            `SKJCU_C_MINUS: condMet = v[`SKJCU_SIGN_BIT];
            `SKJCU_C_ZERO: condMet = (v == 24'h000000);
            default: condMet = (v != 24'h000000);
         endcase
      end
   endfunction

   // Closed rotate keeps bit 23 by moving it into bit 0.
   wire [23:0] rotWord = {memRdata[22:0], memRdata[23]};
   // Both differences wrap at 24 bits; a difference that overflows is
   // tested by the sign it wraps to, as the arithmetic unit would see it.
   wire [23:0] csubOp = accA - memRdata;
   wire [23:0] mcmpOp = accA - (extQ & memRdata);

   // Memory operand selected by the held opcode.
   // Only the four memory kinds reach the read state, so the default is the plain test.
   reg [23:0] memOp;
   always @* begin
      case (op_q)
         `SKJCU_OP_SROT: memOp = rotWord;
         `SKJCU_OP_MCMP: memOp = mcmpOp;
         `SKJCU_OP_CSUB: memOp = csubOp;
         default: memOp = memRdata;
      endcase
   end
   wire memSkip = condMet(cond_q, memOp);

   // Indicator group: each set address bit selects one test.
   // Several select bits may be set at once: any true test skips, and
   // every selected indicator except the lamp is cleared in the same cycle; the lamp bit sets the lamp.
   wire iOvf = adrIn[`SKJCU_I_OVF];
   wire iDiv = adrIn[`SKJCU_I_DIV];
   wire iPar = adrIn[`SKJCU_I_PAR];
   wire iRng = adrIn[`SKJCU_I_RNG];
   wire iLamp = adrIn[`SKJCU_I_LAMP];
   wire indSkip = (iOvf & ovf_q)
      | (iDiv & divErr_q)
      | (iPar & parOdd_q)
      | (adrIn[`SKJCU_I_ACCNEG] & accA[`SKJCU_SIGN_BIT])
      | (adrIn[`SKJCU_I_EXTNEG] & extQ[`SKJCU_SIGN_BIT])
      | (adrIn[`SKJCU_I_ACCZ] & (accA == 24'h000000))
      | (iRng & rangeOvf_q)
      | (adrIn[`SKJCU_I_LOCK] & ~masterLockout);
   wire isInd = start & (opIn == `SKJCU_OP_SENSE) & (condIn == `SKJCU_G_IND);

   // One-cycle sense skips; the indicator group uses the raw
   // address field so indexing and indirection never reach it.
   reg senseSkip;
   always @* begin
      case (condIn)
         `SKJCU_G_SWITCH: senseSkip = |(senseSw & maskIn);
         `SKJCU_G_INRDY: senseSkip = |(chanInAvail & maskIn);
         `SKJCU_G_OUTLN: senseSkip = |(chanOutAvail & maskIn);
         default: senseSkip = indSkip;
      endcase
   end

   // One-cycle jump conditions.
   // Designator 3 of the accumulator jump is the extension test; a switch
   // jump with designator 0 or 3 is outside this unit and never jumps here.
   reg jumpCond;
   always @* begin
      jumpCond = 1'b0;
      if (opIn == `SKJCU_OP_JACC) begin
         if (condIn == `SKJCU_J_QPLUS)
            jumpCond = ~extQ[`SKJCU_SIGN_BIT];
         else if (condIn != `SKJCU_C_NZERO)
            jumpCond = condMet(condIn, accA);
      end else if (opIn == `SKJCU_OP_JSW) begin
         if (condIn == `SKJCU_J_SW1)
            jumpCond = senseSw[1];
         else if (condIn == `SKJCU_J_SW2)
            jumpCond = senseSw[2];
      end
   end

   // Next-address adders; the held copies serve the memory kinds, whose
   // curPc may already have moved on by the time the memory answers.
   wire [13:0] pcPlus1 = curPc + 14'h0001;
   wire [13:0] pcPlus2 = curPc + 14'h0002;
   wire [13:0] heldPlus1 = pc_q + 14'h0001;
   wire [13:0] heldPlus2 = pc_q + 14'h0002;
   wire needsMem = (opIn == `SKJCU_OP_STEST) | (opIn == `SKJCU_OP_SROT)
      | (opIn == `SKJCU_OP_MCMP) | (opIn == `SKJCU_OP_CSUB);
   wire isJump = (opIn == `SKJCU_OP_JACC) | (opIn == `SKJCU_OP_JSW);

   // Sequencing: one-cycle kinds finish on the edge after start,
   // memory kinds wait for the read and, for rotate, the write back.
   // Rotate waits for the write acknowledge before done, so the rewritten
   // word is in core before the next instruction can read it.
   reg [23:0] rotHeld_q;
   reg skipHeld_q;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         op_q <= 5'h00;
         cond_q <= 2'h0;
         pc_q <= 14'h0000;
         memRd_q <= 1'b0;
         memWr_q <= 1'b0;
         memAddr_q <= 14'h0000;
         memWdata_q <= 24'h000000;
         done_q <= 1'b0;
         pcNext_q <= 14'h0000;
         skipTaken_q <= 1'b0;
         jumpTaken_q <= 1'b0;
         rotHeld_q <= 24'h000000;
         skipHeld_q <= 1'b0;
      end else begin
         // Done is a one-cycle pulse unless a branch below raises it.
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  op_q <= opIn;
                  cond_q <= condIn;
                  pc_q <= curPc;
                  if (needsMem) begin
                     memRd_q <= 1'b1;
                     // Storage skips take no indirection.
                     if (opIn == `SKJCU_OP_STEST || opIn == `SKJCU_OP_SROT)
                        memAddr_q <= idxAddr;
                     else
                        memAddr_q <= effAddr;
                     state_q <= S_READ;
                  end else if (isJump) begin
                     done_q <= 1'b1;
                     skipTaken_q <= 1'b0;
                     jumpTaken_q <= jumpCond;
                     pcNext_q <= jumpCond ? effAddr : pcPlus1;
                  end else begin
                     done_q <= 1'b1;
                     jumpTaken_q <= 1'b0;
                     if (opIn == `SKJCU_OP_SENSE) begin
                        skipTaken_q <= senseSkip;
                        pcNext_q <= senseSkip ? pcPlus2 : pcPlus1;
                     end else begin
                        // Unknown opcodes fall through in sequence.
                        skipTaken_q <= 1'b0;
                        pcNext_q <= pcPlus1;
                     end
                  end
               end
            end
            // Read data stand only with the acknowledge, so the skip is
            // decided here and held through the rotate's write phase.
            S_READ: begin
               if (memAck) begin
                  memRd_q <= 1'b0;
                  if (op_q == `SKJCU_OP_SROT) begin
                     memWr_q <= 1'b1;
                     memWdata_q <= rotWord;
                     skipHeld_q <= memSkip;
                     rotHeld_q <= rotWord;
                     state_q <= S_WRITE;
                  end else begin
                     done_q <= 1'b1;
                     jumpTaken_q <= 1'b0;
                     skipTaken_q <= memSkip;
                     pcNext_q <= memSkip ? heldPlus2 : heldPlus1;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_WRITE: begin
               if (memAck) begin
                  memWr_q <= 1'b0;
                  done_q <= 1'b1;
                  jumpTaken_q <= 1'b0;
                  skipTaken_q <= skipHeld_q;
                  pcNext_q <= skipHeld_q ? heldPlus2 : heldPlus1;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Ready tracks idle and software enable, so a disabled unit
   // simply holds off the sequencer rather than dropping work.
   // It falls in the cycle after a take, which keeps a word that
   // the sequencer still offers from being taken twice.
   // A memory kind keeps it low until its done pulse has gone out,
   // so the sequencer never overlaps two instructions.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= enable_q & (state_q == S_IDLE) & ~start;
      end
   end

   // Indicators: an event in the clearing cycle wins over the clear.
   // Each clear acts only at the take edge of the indicator group instruction.
   wire clrOvf = isInd & iOvf;
   wire clrDiv = isInd & iDiv;
   wire clrPar = isInd & iPar;
   wire clrRng = isInd & iRng;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_q <= 1'b0;
         divErr_q <= 1'b0;
         parOdd_q <= 1'b0;
         rangeOvf_q <= 1'b0;
         lamp_q <= 1'b0;
      end else begin
         ovf_q <= ovfSet | (ovf_q & ~clrOvf);
         divErr_q <= divErrSet | (divErr_q & ~clrDiv);
         // A shifted-out one arriving with the reset still flips it.
         parOdd_q <= (parOdd_q & ~clrPar) ^ shiftOne;
         rangeOvf_q <= rangeOvfSet | (rangeOvf_q & ~clrRng);
         // The operator press clears, the instruction only sets.
         lamp_q <= (isInd & iLamp) | (lamp_q & ~lampPress);
      end
   end

   // APB slave: data is prepared in the setup cycle so the access
   // phase always completes at its first edge with no wait states.
   // Read data are captured at setup, so a flag that changes during the
   // access phase is reported as it stood one cycle earlier.
   // Unmapped addresses answer with an error; writes to them change nothing.
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire mapped = (paddr == `SKJCU_A_CTRL) | (paddr == `SKJCU_A_STAT)
      | (paddr == `SKJCU_A_PC);
   reg [31:0] rdMux;
   always @* begin
      case (paddr)
         `SKJCU_A_CTRL: rdMux = {31'h00000000, enable_q};
         // Status packs the live state code above the seven flags.
         `SKJCU_A_STAT: rdMux = {22'h000000, state_q, lamp_q,
            rangeOvf_q, parOdd_q, divErr_q, ovf_q, masterLockout,
            ready_q};
         `SKJCU_A_PC: rdMux = {18'h00000, pcNext_q};
         default: rdMux = 32'h00000000;
      endcase
   end
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         enable_q <= `SKJCU_CTRL_RST;
      end else begin
         pready_q <= 1'b1;
         if (setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rdMux;
            pslverr_q <= ~mapped;
         end
         if (access && pwrite && paddr == `SKJCU_A_CTRL)
            enable_q <= pwdata[0];
      end
   end

endmodule // skjcu_unit

`default_nettype wire

// file: testbench/skjcu_unit_monitor.sv
// Checker for the skip and jump unit, bound to its top module.
// Assumes the sequencer holds the word, curPc and effAddr while a take is sampled.
`timescale 1ns/1ps
`default_nettype none
`include "skjcu_defs.vh"
module skjcu_unit_monitor (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Instruction and operands.
   input wire logic instValid,
   input wire logic [23:0] instWord,
   input wire logic [13:0] effAddr,
   input wire logic [13:0] curPc,
   input wire logic [23:0] extQ,
   input wire logic [15:0] senseSw,
   input wire logic [15:0] chanInAvail,
   input wire logic ovfSet,
   input wire logic lampPress,
   // Memory port.
   input wire logic memAck,
   input wire logic [23:0] memRdata,
   input wire logic memRd_q,
   input wire logic [13:0] memAddr_q,
   input wire logic memWr_q,
   input wire logic [23:0] memWdata_q,
   // Results.
   input wire logic ready_q,
   input wire logic done_q,
   input wire logic [13:0] pcNext_q,
   input wire logic skipTaken_q,
   input wire logic jumpTaken_q,
   input wire logic ovf_q,
   input wire logic lamp_q
);
   // A take is the edge where an offered word meets an idle unit.
   wire tk = instValid && ready_q;
   wire [4:0] op = instWord[22:18];
   wire [1:0] cd = instWord[17:16];
   wire sns = tk && op == `SKJCU_OP_SENSE;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // The write-back must carry the read word turned one place left, top bit wrapped.
   sequence s_rdAck; memRd_q && memAck; endsequence
   sequence s_done; done_q; endsequence
   sequence s_wrBack; memWr_q && memWdata_q == {$past(memRdata[22:0]), $past(memRdata[23])}; endsequence
   chk_sense_once: assert property (sns |=> done_q ##1 !done_q)
      else $error("sense group not one cycle");
   chk_switch_skip: assert property (sns && cd == 2'h0 |=> skipTaken_q == |($past(senseSw) & $past(instWord[15:0])))
      else $error("switch skip wrong");
   chk_input_skip: assert property (sns && cd == 2'h1 |=> skipTaken_q == |($past(chanInAvail) & $past(instWord[15:0])))
      else $error("input ready skip wrong");
   chk_skip_pc: assert property (sns |=> pcNext_q == $past(curPc) + (skipTaken_q ? 14'h0002 : 14'h0001))
      else $error("skip next address wrong");
   chk_ovf_clear: assert property (sns && cd == 2'h3 && instWord[0] && !ovfSet |=> !ovf_q && (skipTaken_q || !$past(ovf_q)))
      else $error("overflow skip wrong");
   chk_lamp_hold: assert property (lamp_q && !lampPress |=> lamp_q)
      else $error("lamp cleared by logic");
   chk_qplus_jump: assert property (tk && op == `SKJCU_OP_JACC && cd == 2'h3 |=> jumpTaken_q != $past(extQ[23]) && pcNext_q == (jumpTaken_q ? $past(effAddr) : $past(curPc) + 14'h0001))
      else $error("extension jump wrong");
   chk_rotate_wb: assert property (s_rdAck |=> s_done or s_wrBack)
      else $error("rotate write-back wrong");
   chk_read_hold: assert property (memRd_q && !memAck |=> memRd_q && $stable(memAddr_q))
      else $error("read request dropped");
endmodule // skjcu_unit_monitor
bind skjcu_unit skjcu_unit_monitor u_mon (.mclk, .rst_n, .instValid, .instWord, .effAddr, .curPc, .extQ, .senseSw,
   .chanInAvail, .ovfSet, .lampPress, .memAck, .memRdata, .memRd_q, .memAddr_q, .memWr_q, .memWdata_q,
   .ready_q, .done_q, .pcNext_q, .skipTaken_q, .jumpTaken_q, .ovf_q, .lamp_q);
`default_nettype wire

// file: testbench/skjcu_mem_model.sv
// Core memory partner: answers a request after one cycle, or three when slow.
// Assumes requests stay up until the acknowledge is seen.
`timescale 1ns/1ps
`default_nettype none
module skjcu_mem_model (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Request side.
   input wire logic rd,
   input wire logic wr,
   input wire logic [13:0] addr,
   input wire logic [23:0] wdata,
   input wire logic slow,
   // Answer side.
   output logic ack,
   output logic [23:0] rdata
);
   logic [23:0] mem [0:15];
   logic [1:0] waitCnt;
   // Data lines toggle outside answers so a late sample sees an inverted word.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         waitCnt <= 2'h0;
         rdata <= 24'h000000;
      end else if ((rd || wr) && !ack && (waitCnt == 2'h2 || !slow)) begin
         ack <= 1'b1;
         waitCnt <= 2'h0;
         rdata <= mem[addr[3:0]];
         if (wr) begin
            mem[addr[3:0]] <= wdata;
         end
      end else begin
         ack <= 1'b0;
         rdata <= ~rdata;
         if ((rd || wr) && !ack) begin
            waitCnt <= waitCnt + 2'h1;
         end
      end
   end
endmodule // skjcu_mem_model
`default_nettype wire

// file: testbench/test_skip_jump_condition_unit.sv
// Self-checking bench for the skip and jump unit with a core memory model.
// Assumes curPc, idxAddr and effAddr stay fixed while an instruction runs.
`timescale 1ns/1ps
`default_nettype none
`include "skjcu_defs.vh"
module test_skip_jump_condition_unit;
   logic mclk, rst_n, instValid, masterLockout, lampPress, ovfSet, divErrSet, shiftOne, rangeOvfSet, slow;
   logic psel, penable, pwrite, memAck, memRd_q, memWr_q, ready_q, done_q, skipTaken_q, jumpTaken_q;
   logic ovf_q, divErr_q, parOdd_q, rangeOvf_q, lamp_q, pready_q, pslverr_q;
   logic [23:0] instWord, accA, extQ, memRdata, memWdata_q;
   logic [13:0] idxAddr, effAddr, curPc, memAddr_q, pcNext_q;
   logic [15:0] senseSw, chanInAvail, chanOutAvail;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata_q, r;
   logic e;
   int errors = 0, cmp_count = 0, cyc = 0;
   skjcu_unit u_dut (.mclk, .rst_n, .instValid, .instWord, .idxAddr, .effAddr, .curPc, .accA, .extQ, .senseSw,
      .chanInAvail, .chanOutAvail, .masterLockout, .lampPress, .ovfSet, .divErrSet, .shiftOne, .rangeOvfSet, .memAck,
      .memRdata, .memRd_q, .memWr_q, .memAddr_q, .memWdata_q, .ready_q, .done_q, .pcNext_q, .skipTaken_q, .jumpTaken_q,
      .ovf_q, .divErr_q, .parOdd_q, .rangeOvf_q, .lamp_q, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
      .pready_q, .pslverr_q);
   skjcu_mem_model u_mem (.mclk, .rst_n, .rd(memRd_q), .wr(memWr_q), .addr(memAddr_q), .wdata(memWdata_q), .slow,
      .ack(memAck), .rdata(memRdata));
   task automatic report_and_stop;
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic skp(input logic t);
      chk(skipTaken_q, t);
      chk(pcNext_q, curPc + (t ? 14'h0002 : 14'h0001));
   endtask
   function automatic logic [23:0] iw(input logic [4:0] op, input logic [1:0] c, input logic [15:0] f);
      return {1'b1, op, c, f};
   endfunction
   // Offer one word until it is taken, then wait a bounded time for done.
   task automatic run(input logic [23:0] w);
      int n;
      @(posedge mclk);
      instValid <= 1'b1;
      instWord <= w;
      do @(posedge mclk); while (ready_q !== 1'b1);
      instValid <= 1'b0;
      for (n = 0; n < 40 && done_q !== 1'b1; n++) @(negedge mclk);
      if (done_q !== 1'b1) begin
         errors++;
         $display("FAIL %0t: no done for word %h", $time, w);
      end
   endtask
   task automatic ind(input int b, input logic t);
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_IND, 16'h0001 << b));
      skp(t);
   endtask
   task automatic t_storage;
      u_mem.mem[5] = 24'h800000;
      u_mem.mem[6] = 24'h000000;
      for (int c = 0; c < 4; c++) begin
         @(posedge mclk);
         slow <= c[0];
         run(iw(`SKJCU_OP_STEST, c[1:0], 16'h0005));
         skp(c[0]);
      end
      chk(u_mem.mem[5], 24'h800000);
   endtask
   task automatic t_rotate;
      u_mem.mem[5] = 24'h800001;
      run(iw(`SKJCU_OP_SROT, `SKJCU_C_NZERO, 16'h0005));
      skp(1'b1);
      chk(u_mem.mem[5], 24'h000003);
      run(iw(`SKJCU_OP_SROT, `SKJCU_C_MINUS, 16'h0005));
      skp(1'b0);
      chk(u_mem.mem[5], 24'h000006);
   endtask
   task automatic t_compare;
      @(posedge mclk);
      accA <= 24'h000010;
      extQ <= 24'h00000f;
      u_mem.mem[6] = 24'h000010;
      run(iw(`SKJCU_OP_CSUB, `SKJCU_C_ZERO, 16'h0005));
      skp(1'b1);
      run(iw(`SKJCU_OP_MCMP, `SKJCU_C_ZERO, 16'h0005));
      skp(1'b0);
      run(iw(`SKJCU_OP_MCMP, `SKJCU_C_PLUS, 16'h0005));
      skp(1'b1);
      chk(u_mem.mem[6], 24'h000010);
   endtask
   task automatic t_sense;
      @(posedge mclk);
      senseSw <= 16'h0100;
      chanInAvail <= 16'h0002;
      chanOutAvail <= 16'h8000;
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_SWITCH, 16'h0100));
      skp(1'b1);
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_SWITCH, 16'hfeff));
      skp(1'b0);
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_INRDY, 16'h0003));
      skp(1'b1);
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_OUTLN, 16'h7fff));
      skp(1'b0);
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_OUTLN, 16'h8000));
      skp(1'b1);
   endtask
   // Each indicator is set by its event, skips once, and is clear the second time.
   task automatic t_ind;
      int bits [4] = '{0, 3, 12, 6};
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {shiftOne, rangeOvfSet, divErrSet, ovfSet} <= 4'h1 << i;
         @(posedge mclk);
         {shiftOne, rangeOvfSet, divErrSet, ovfSet} <= 4'h0;
         ind(bits[i], 1'b1);
         chk({parOdd_q, rangeOvf_q, divErr_q, ovf_q}, 4'h0);
         ind(bits[i], 1'b0);
      end
      @(posedge mclk);
      accA <= 24'h800000;
      extQ <= 24'h000000;
      masterLockout <= 1'b1;
      ind(9, 1'b1);
      ind(10, 1'b0);
      ind(11, 1'b0);
      ind(13, 1'b0);
      @(posedge mclk);
      masterLockout <= 1'b0;
      ind(13, 1'b1);
   endtask
   task automatic t_lamp;
      run(iw(`SKJCU_OP_SENSE, `SKJCU_G_IND, 16'h0004));
      repeat (3) @(negedge mclk);
      chk(lamp_q, 1'b1);
      @(posedge mclk);
      lampPress <= 1'b1;
      @(posedge mclk);
      lampPress <= 1'b0;
      @(negedge mclk);
      chk(lamp_q, 1'b0);
   endtask
   task automatic t_jumps;
      @(posedge mclk);
      accA <= 24'h000000;
      extQ <= 24'h800000;
      senseSw <= 16'h0002;
      ind(10, 1'b1);
      ind(11, 1'b1);
      for (int i = 0; i < 6; i++) begin
         run(iw(i < 4 ? `SKJCU_OP_JACC : `SKJCU_OP_JSW, i < 4 ? i[1:0] : 2'(i - 3), 16'h0123));
         chk(jumpTaken_q, !i[0]);
         chk(pcNext_q, i[0] ? 14'h0101 : 14'h0006);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready_q !== 1'b1);
      r = prdata_q;
      e = pslverr_q;
      {psel, penable} <= 2'h0;
   endtask
   task automatic t_apb;
      apb(1'b0, `SKJCU_A_CTRL, 32'h0);
      chk({e, r[22:0]}, 24'h000001);
      apb(1'b1, `SKJCU_A_CTRL, 32'h0);
      repeat (2) @(negedge mclk);
      chk(ready_q, 1'b0);
      apb(1'b1, `SKJCU_A_CTRL, 32'h1);
      apb(1'b0, `SKJCU_A_PC, 32'h0);
      chk(r[23:0], 24'h000101);
      apb(1'b0, `SKJCU_A_STAT, 32'h0);
      chk({e, r[22:0]}, 24'h000081);
      apb(1'b0, 8'h0c, 32'h0);
      chk({e, r[22:0]}, 24'h800000);
   endtask
   // Free-running clock.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Hang guard well above the few hundred cycles the run needs.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      {rst_n, instValid, masterLockout, lampPress, ovfSet, divErrSet, shiftOne, rangeOvfSet, slow} = '0;
      {psel, penable, pwrite, instWord, accA, extQ, senseSw, chanInAvail, chanOutAvail, paddr, pwdata} = '0;
      {idxAddr, effAddr, curPc} = {14'h0005, 14'h0006, 14'h0100};
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_storage;
      t_rotate;
      t_compare;
      t_sense;
      t_ind;
      t_lamp;
      t_jumps;
      t_apb;
      report_and_stop;
   end
endmodule // test_skip_jump_condition_unit
`default_nettype wire
